// ==== hdl/converter_fault_and_power_good.sv ====
// Protection and power-good supervisor for a step-down converter.
// Assumes measurement codes, pwm requests and ramp handshake on pclk.
`timescale 1ns/1ps
module converter_fault_and_power_good #(
    parameter int MS_CYCLES    = fault_pkg::MS_CYC,
    parameter int RETRY_CYCLES = fault_pkg::RETRY_MS * fault_pkg::MS_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [11:0]        vout_code,
    input  wire logic [11:0]        vset_code,
    input  wire logic [11:0]        vtrack_code,
    input  wire logic signed [15:0] temp_dc,
    input  wire logic               ramping_up,
    input  wire logic               ov_detect,
    input  wire logic               ramp_done,
    input  wire logic               pwm_hs,
    input  wire logic               pwm_ls,
    output logic                    hs_drive,
    output logic                    ls_drive,
    output logic                    ramp_down_req,
    output logic [2:0]              fall_slew_sel,
    output logic                    output_in_window_signal,
    output logic                    overheat_warning_flag,
    output logic                    irq
);
    logic [18:0] ctrl_q, ctrl_d;
    logic [8:0]  toff_q, toff_d;
    logic [5:0]  stat_q, stat_d, irq_en_q, irq_en_d, ev;
    logic        wr, rd_ok;
    // APB decode, zero wait states
    assign wr      = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign rd_ok   = paddr inside {fault_pkg::OFS_CTRL, fault_pkg::OFS_TOFF,
                     fault_pkg::OFS_STAT, fault_pkg::OFS_IRQ_EN, fault_pkg::OFS_CLR,
                     fault_pkg::OFS_LIVE};
    assign pslverr = psel && penable && !rd_ok;

    // Measured window comparisons, percent of setpoint
    logic [18:0] vout_pct, uv_lvl, pg_lo_lvl, pg_hi_lvl;
    logic [6:0]  uv_pct;
    logic [11:0] trk_dev;
    logic        running;
    fault_pkg::state_e st_q, st_d;
    assign vout_pct  = 19'(vout_code) * 19'd100;
    assign uv_pct    = fault_pkg::UV_PCT_BASE
                     + 7'(ctrl_q[fault_pkg::CTL_UV_SEL +: 2]) * fault_pkg::PCT_STEP;
    assign uv_lvl    = 19'(vset_code) * 19'(uv_pct);
    assign pg_lo_lvl = 19'(vset_code) * 19'(ctrl_q[fault_pkg::CTL_PG_LO95]
                     ? fault_pkg::PG_LO_PCT + fault_pkg::PCT_STEP : fault_pkg::PG_LO_PCT);
    assign pg_hi_lvl = 19'(vset_code) * 19'(ctrl_q[fault_pkg::CTL_PG_HI105]
                     ? fault_pkg::PG_HI_PCT - fault_pkg::PCT_STEP : fault_pkg::PG_HI_PCT);
    assign trk_dev   = (vout_code > vtrack_code) ? vout_code - vtrack_code
                                                 : vtrack_code - vout_code;
    assign running   = (st_q == fault_pkg::ST_RUN);

    // Overheat warning with hysteresis
    logic warn_q, warn_d;
    always_comb
    begin
        warn_d = warn_q;
        if (temp_dc >= fault_pkg::WARN_SET_DC)
            warn_d = 1'b1;
        else if (temp_dc < fault_pkg::WARN_SET_DC - fault_pkg::WARN_HYST_DC)
            warn_d = 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            warn_q <= 1'b0;
        else
            warn_q <= warn_d;
    end
    assign overheat_warning_flag = warn_q;

    // Raw trip conditions: uv, ot, tr
    logic [2:0] raw, trip;
    assign raw[0] = running && !ramping_up && (vout_pct <= uv_lvl);
    assign raw[1] = running && (temp_dc >= fault_pkg::OT_TRIP_DC);
    assign raw[2] = running && ctrl_q[fault_pkg::CTL_TR_EN] && ramping_up
                    && (trk_dev > fault_pkg::TRACK_CODES);

    // Persistence filter for each of uv, ot and tr
    genvar gi;
    for (gi = 0; gi < 3; gi++)
    begin : g_filt
        logic [9:0] cnt_q, cnt_d;
        always_comb
        begin
            cnt_d = raw[gi] ? ((cnt_q == fault_pkg::TRIP_CYC) ? cnt_q : cnt_q + 10'd1)
                            : 10'd0;
        end
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cnt_q <= 10'd0;
            else
                cnt_q <= cnt_d;
        end
        assign trip[gi] = raw[gi] && (cnt_q == fault_pkg::TRIP_CYC - 10'd1);
    end

    // Shutdown sequencer
    logic [31:0] tmr_q, tmr_d;
    logic        cat_q, cat_d, latch_q, latch_d, ot_hold_q, ot_hold_d;
    logic        fault_any, crit, catas, latch_sel, stop_cmd;
    logic [3:0]  fault_vec;
    assign fault_vec = {running && ov_detect, trip};
    assign fault_any = |fault_vec;
    assign catas     = fault_vec[3] && !ctrl_q[fault_pkg::CTL_OV_CRIT];
    assign crit      = (fault_vec[3] && ctrl_q[fault_pkg::CTL_OV_CRIT])
                     || (trip[0] && ctrl_q[fault_pkg::CTL_UV_CRIT])
                     || (trip[1] && ctrl_q[fault_pkg::CTL_OT_CRIT])
                     || (trip[2] && ctrl_q[fault_pkg::CTL_TR_CRIT]);
    assign latch_sel = |(fault_vec & ctrl_q[fault_pkg::CTL_LATCH +: 4]);
    assign stop_cmd  = !ctrl_q[fault_pkg::CTL_RUN];

    always_comb
    begin
        st_d      = st_q;
        tmr_d     = (tmr_q == 32'd0) ? 32'd0 : tmr_q - 32'd1;
        cat_d     = cat_q;
        latch_d   = latch_q;
        ot_hold_d = ot_hold_q;
        if (!warn_q)
            ot_hold_d = 1'b0;
        if (trip[1])
            ot_hold_d = 1'b1;
        case (st_q)
            fault_pkg::ST_OFF:
            begin
                cat_d = 1'b0;
                if (!stop_cmd)
                    st_d = fault_pkg::ST_RUN;
            end
            fault_pkg::ST_RUN:
            begin
                if (fault_any)
                begin
                    latch_d = latch_sel;
                    if (crit || catas)
                    begin
                        cat_d = catas;
                        tmr_d = 32'(RETRY_CYCLES);
                        st_d  = latch_sel ? fault_pkg::ST_LATCH : fault_pkg::ST_RETRY;
                    end
                    else
                    begin
                        tmr_d = 32'(toff_q[5:0]) * 32'(MS_CYCLES);
                        st_d  = fault_pkg::ST_SEQ_WAIT;
                    end
                end
                else if (stop_cmd)
                begin
                    latch_d = 1'b0;
                    tmr_d   = 32'(toff_q[5:0]) * 32'(MS_CYCLES);
                    st_d    = fault_pkg::ST_SEQ_WAIT;
                end
            end
            fault_pkg::ST_SEQ_WAIT:
            begin
                if (tmr_q == 32'd0)
                    st_d = fault_pkg::ST_RAMP;
            end
            fault_pkg::ST_RAMP:
            begin
                if (ramp_done)
                begin
                    tmr_d = 32'(RETRY_CYCLES);
                    if (stop_cmd && !latch_q)
                        st_d = fault_pkg::ST_OFF;
                    else
                        st_d = latch_q ? fault_pkg::ST_LATCH : fault_pkg::ST_RETRY;
                end
            end
            fault_pkg::ST_RETRY:
            begin
                if (stop_cmd)
                    st_d = fault_pkg::ST_OFF;
                else if (tmr_q == 32'd0 && !ot_hold_d)
                begin
                    cat_d = 1'b0;
                    st_d  = fault_pkg::ST_RUN;
                end
            end
            fault_pkg::ST_LATCH:
            begin
                if (stop_cmd)
                    st_d = fault_pkg::ST_OFF;
            end
            default:
                st_d = fault_pkg::ST_OFF;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q      <= fault_pkg::ST_OFF;
            tmr_q     <= 32'd0;
            cat_q     <= 1'b0;
            latch_q   <= 1'b0;
            ot_hold_q <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            tmr_q     <= tmr_d;
            cat_q     <= cat_d;
            latch_q   <= latch_d;
            ot_hold_q <= ot_hold_d;
        end
    end

    // Switch drive outputs
    logic hs_d, ls_d, on_path;
    assign on_path = (st_q == fault_pkg::ST_RUN) || (st_q == fault_pkg::ST_SEQ_WAIT)
                   || (st_q == fault_pkg::ST_RAMP);
    always_comb
    begin
        hs_d = 1'b0;
        ls_d = cat_d;
        if (on_path && st_d != fault_pkg::ST_RETRY && st_d != fault_pkg::ST_LATCH)
        begin
            hs_d = pwm_hs;
            ls_d = pwm_ls;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hs_drive <= 1'b0;
            ls_drive <= 1'b0;
        end
        else
        begin
            hs_drive <= hs_d;
            ls_drive <= ls_d;
        end
    end
    assign ramp_down_req = (st_q == fault_pkg::ST_RAMP);
    assign fall_slew_sel = toff_q[8:6];

    // Power-good timing
    logic [31:0] pg_tmr_q, pg_tmr_d, on_dly, off_dly;
    logic        pg_q, pg_d, in_win, pg_drop, off_arm_q, off_arm_d;
    function automatic logic [31:0] dly_cyc(input logic [1:0] sel, input int ms_cyc);
        logic [7:0] ms;
        ms = (sel == 2'd1) ? fault_pkg::PG_DLY_MS1 : (sel == 2'd2) ? fault_pkg::PG_DLY_MS2
           : (sel == 2'd3) ? fault_pkg::PG_DLY_MS3 : 8'd0;
        return 32'(ms) * 32'(ms_cyc);
    endfunction : dly_cyc
    assign on_dly  = dly_cyc(ctrl_q[fault_pkg::CTL_PG_ON +: 2], MS_CYCLES);
    assign off_dly = dly_cyc(ctrl_q[fault_pkg::CTL_PG_OFF +: 2], MS_CYCLES);
    assign in_win  = running && (vout_pct >= pg_lo_lvl) && (vout_pct <= pg_hi_lvl);
    always_comb
    begin
        pg_d      = pg_q;
        pg_tmr_d  = pg_tmr_q;
        off_arm_d = off_arm_q;
        // Drop above window; outside reset mode also at UV level or off path; in reset mode when off delay ends
        pg_drop   = (vout_pct > pg_hi_lvl) || (!on_path && !ctrl_q[fault_pkg::CTL_PG_RST])
                  || (!ctrl_q[fault_pkg::CTL_PG_RST] && vout_pct <= uv_lvl)
                  || (off_arm_q && pg_tmr_q == 32'd0);
        if (pg_q)
        begin
            if (ctrl_q[fault_pkg::CTL_PG_RST] && !off_arm_q && !running)
            begin
                off_arm_d = 1'b1;
                pg_tmr_d  = off_dly;
            end
            else if (pg_tmr_q != 32'd0)
                pg_tmr_d = pg_tmr_q - 32'd1;
            if (pg_drop)
            begin
                pg_d      = 1'b0;
                off_arm_d = 1'b0;
            end
        end
        else if (!in_win)
            pg_tmr_d = on_dly;
        else if (pg_tmr_q == 32'd0)
            pg_d = 1'b1;
        else
            pg_tmr_d = pg_tmr_q - 32'd1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pg_q      <= 1'b0;
            pg_tmr_q  <= 32'd0;
            off_arm_q <= 1'b0;
        end
        else
        begin
            pg_q      <= pg_d;
            pg_tmr_q  <= pg_tmr_d;
            off_arm_q <= off_arm_d;
        end
    end
    assign output_in_window_signal = pg_q;

    // Events and register file; a set wins over a clear
    assign ev = {pg_q && !pg_d, warn_d && !warn_q, fault_vec & {4{running}}};
    always_comb
    begin
        ctrl_d   = ctrl_q;
        toff_d   = toff_q;
        irq_en_d = irq_en_q;
        stat_d   = stat_q;
        if (wr && paddr == fault_pkg::OFS_CTRL)
            ctrl_d = pwdata[fault_pkg::CTL_W-1:0];
        if (wr && paddr == fault_pkg::OFS_TOFF)
            toff_d = pwdata[8:0];
        if (wr && paddr == fault_pkg::OFS_IRQ_EN)
            irq_en_d = pwdata[fault_pkg::EV_W-1:0];
        if (wr && paddr == fault_pkg::OFS_CLR)
            stat_d = stat_q & ~pwdata[fault_pkg::EV_W-1:0];
        stat_d = stat_d | ev;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= fault_pkg::CTRL_RESET;
            toff_q   <= fault_pkg::TOFF_RESET;
            irq_en_q <= 6'h00;
            stat_q   <= 6'h00;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            toff_q   <= toff_d;
            irq_en_q <= irq_en_d;
            stat_q   <= stat_d;
        end
    end
    assign irq = |(stat_q & irq_en_q);

    // Read mux, write-only clear reads zero
    always_comb
    begin
        case (paddr)
            fault_pkg::OFS_CTRL:   prdata = 32'(ctrl_q);
            fault_pkg::OFS_TOFF:   prdata = 32'(toff_q);
            fault_pkg::OFS_STAT:   prdata = 32'(stat_q);
            fault_pkg::OFS_IRQ_EN: prdata = 32'(irq_en_q);
            fault_pkg::OFS_LIVE:   prdata = {24'h000000, ot_hold_q, latch_q, cat_q,
                                             3'(st_q), pg_q, warn_q};
            default:               prdata = 32'h00000000;
        endcase
    end
endmodule : converter_fault_and_power_good

// ==== include/fault_pkg.sv ====
// Constants for the converter fault and power-good supervisor.
// Assumes 12-bit voltage codes of 2.5 mV and temperature in 0.1 degC steps.
package fault_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TOFF   = 8'h04;
    localparam logic [7:0] OFS_STAT   = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
    localparam logic [7:0] OFS_CLR    = 8'h10;
    localparam logic [7:0] OFS_LIVE   = 8'h14;
    // Control field positions
    localparam int CTL_RUN      = 0;
    localparam int CTL_UV_SEL   = 1;  // two bits
    localparam int CTL_OV_CRIT  = 3;
    localparam int CTL_UV_CRIT  = 4;
    localparam int CTL_OT_CRIT  = 5;
    localparam int CTL_TR_CRIT  = 6;
    localparam int CTL_LATCH    = 7;  // four bits: uv, ot, tr, ov
    localparam int CTL_TR_EN    = 11;
    localparam int CTL_PG_LO95  = 12;
    localparam int CTL_PG_HI105 = 13;
    localparam int CTL_PG_ON    = 14; // two bits
    localparam int CTL_PG_RST   = 16;
    localparam int CTL_PG_OFF   = 17; // two bits
    localparam int CTL_W        = 19;
    localparam logic [18:0] CTRL_RESET = 19'h00000;
    localparam logic [8:0]  TOFF_RESET = 9'h000;
    // Event bits
    localparam int EV_UV = 0;
    localparam int EV_OT = 1;
    localparam int EV_TR = 2;
    localparam int EV_OV = 3;
    localparam int EV_WARN = 4;
    localparam int EV_PG_FALL = 5;
    localparam int EV_W = 6;
    // Thresholds in percent of setpoint
    localparam logic [6:0] UV_PCT_BASE = 7'd75;
    localparam logic [6:0] PCT_STEP    = 7'd5;
    localparam logic [6:0] PG_LO_PCT   = 7'd90;
    localparam logic [6:0] PG_HI_PCT   = 7'd110;
    // Temperature in 0.1 degC
    localparam logic signed [15:0] OT_TRIP_DC    = 16'sd1200;
    localparam logic signed [15:0] WARN_SET_DC   = 16'sd1100;
    localparam logic signed [15:0] WARN_HYST_DC  = 16'sd17;
    // Tracking window in mV and in codes of 2.5 mV
    localparam int TRACK_MV = 250;
    localparam logic [11:0] TRACK_CODES = 12'(TRACK_MV * 10 / 25);
    // Trip filter time
    localparam int CLK_MHZ = 100;
    localparam int TRIP_US = 6;
    localparam logic [9:0] TRIP_CYC = 10'(TRIP_US * CLK_MHZ);
    // Times in ms, and pclk cycles per ms
    localparam int RETRY_MS = 130;
    localparam int MS_CYC   = 1000 * CLK_MHZ;
    localparam logic [7:0] PG_DLY_MS1 = 8'd10;
    localparam logic [7:0] PG_DLY_MS2 = 8'd50;
    localparam logic [7:0] PG_DLY_MS3 = 8'd150;
    typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_SEQ_WAIT, ST_RAMP, ST_RETRY,
                              ST_LATCH} state_e;
endpackage : fault_pkg

// ==== sim/converter_fault_and_power_good_sva.sv ====
// Port-level assertions for the fault and power-good supervisor.
// Bound to the top module; sees only its ports, single pclk domain.
`timescale 1ns/1ps
module converter_fault_and_power_good_sva (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [11:0]        vout_code,
    input wire logic [11:0]        vset_code,
    input wire logic signed [15:0] temp_dc,
    input wire logic               ramp_done,
    input wire logic               hs_drive,
    input wire logic               ls_drive,
    input wire logic               ramp_down_req,
    input wire logic               output_in_window_signal,
    input wire logic               overheat_warning_flag
);
    logic [31:0] vo;
    logic [31:0] vs;
    logic        over;
    logic        under;
    logic        in_win;
    // Output scaled by 100 against setpoint percentages
    assign vo     = 32'(vout_code) * 32'd100;
    assign vs     = 32'(vset_code);
    assign over   = vo > vs * 32'd110;
    assign under  = vo < vs * 32'd90;
    assign in_win = !over && !under;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_slverr; psel && penable && paddr > 8'h14 |-> pslverr && prdata == 32'h0;
    endproperty
    property p_ready; psel && penable |-> pready; endproperty
    property p_warn_set; temp_dc >= fault_pkg::WARN_SET_DC |=> overheat_warning_flag;
    endproperty
    property p_warn_clr; temp_dc < 16'sd1083 |=> !overheat_warning_flag; endproperty
    property p_win_over; over |-> ##[1:2] !output_in_window_signal; endproperty
    property p_win_under;
        vo <= vs * 32'(fault_pkg::UV_PCT_BASE) |-> ##[1:2] !output_in_window_signal;
    endproperty
    property p_win_rise; $rose(output_in_window_signal) |-> $past(in_win); endproperty
    property p_no_shoot; !(hs_drive && ls_drive); endproperty
    property p_ramp_end; ramp_down_req && ramp_done |=> !ramp_down_req; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    a_ready: assert property (p_ready) else $error("access phase without ready");
    a_warn_set: assert property (p_warn_set) else $error("warning not set");
    a_warn_clr: assert property (p_warn_clr) else $error("warning not cleared");
    a_win_over: assert property (p_win_over) else $error("good above window");
    a_win_under: assert property (p_win_under) else $error("good held at undervoltage");
    a_win_rise: assert property (p_win_rise) else $error("good rose outside");
    a_no_shoot: assert property (p_no_shoot) else $error("both drives on");
    a_ramp_end: assert property (p_ramp_end) else $error("ramp request held");
    // Main scenarios reached
    c_cat: cover property (!hs_drive && ls_drive);
    c_ramp: cover property ($rose(ramp_down_req));
    c_good: cover property ($rose(output_in_window_signal));
endmodule : converter_fault_and_power_good_sva
bind converter_fault_and_power_good converter_fault_and_power_good_sva
    converter_fault_and_power_good_sva_inst (.pclk, .presetn, .psel, .penable, .paddr,
    .prdata, .pready, .pslverr, .vout_code, .vset_code, .temp_dc, .ramp_done, .hs_drive,
    .ls_drive, .ramp_down_req, .output_in_window_signal, .overheat_warning_flag);

// ==== sim/converter_fault_and_power_good_tb_top.sv ====
// Self-checking bench for the fault and power-good supervisor.
// Assumes short ms and retry counts set by parameter below.
`timescale 1ns/1ps
module converter_fault_and_power_good_tb_top;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, rdy, perr;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd, seed;
    logic [11:0]        vout_code, vset_code, vtrack_code, vtgt;
    logic signed [15:0] temp_dc;
    logic               ramping_up, ov_detect, ramp_done, pwm_hs, pwm_ls;
    logic               hs_drive, ls_drive, ramp_down_req, good, warn, irq;
    logic [2:0]         fall_slew_sel;
    int                 errors, n_tests;
    converter_fault_and_power_good #(.MS_CYCLES(10), .RETRY_CYCLES(50))
        converter_fault_and_power_good_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vout_code(vout_code), .vset_code(vset_code),
        .vtrack_code(vtrack_code), .temp_dc(temp_dc), .ramping_up(ramping_up),
        .ov_detect(ov_detect), .ramp_done(ramp_done), .pwm_hs(pwm_hs), .pwm_ls(pwm_ls),
        .hs_drive(hs_drive), .ls_drive(ls_drive), .ramp_down_req(ramp_down_req),
        .fall_slew_sel(fall_slew_sel), .output_in_window_signal(good),
        .overheat_warning_flag(warn), .irq(irq));
    power_stage_model power_stage_model_inst (.pclk(pclk), .presetn(presetn),
        .ramp_down_req(ramp_down_req), .vout_target(vtgt), .pwm_hs(pwm_hs),
        .pwm_ls(pwm_ls), .ramp_done(ramp_done), .vout_code(vout_code));
    // Clock at 100 MHz
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Expected power-good: rises in the window, falls above it or at the UV level
    function automatic logic inwin(input logic [11:0] v, input logic [11:0] s, input logic p);
        if (32'(v) * 100 > 32'(s) * 110 || 32'(v) * 100 <= 32'(s) * 75)
            return 1'b0;
        return (32'(v) * 100 >= 32'(s) * 90) ? 1'b1 : p;
    endfunction : inwin
    task automatic complete_run;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic hang;
        errors++;
        $display("MISMATCH t=%0t wait ran out", $time);
        complete_run();
    endtask : hang
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t got %h want %h", $time, g, e);
        end
    endtask : chk32
    task automatic chkb(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask : chkb
    // Ends on the negative edge, where outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : cyc
    // One APB transfer; results taken at the edge that sees pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            rd   = prdata;
            perr = pslverr;
            rdy  = pready;
            if (rdy === 1'b1) break;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) hang();
    endtask : apb
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int i;
        for (i = 0; i < 300; i++)
        begin
            apb(a, 1'b0, 32'h0);
            if ((rd & m) === v) break;
        end
        n_tests++;
        if (i == 300) hang();
    endtask : poll
    // Main sequence
    initial
    begin
        logic signed [15:0] tt [4];
        logic               tw [4];
        logic               eg;
        tt = '{16'sd1099, 16'sd1100, 16'sd1090, 16'sd1082};
        tw = '{1'b0, 1'b1, 1'b1, 1'b0};
        {presetn, psel, penable, pwrite, paddr, pwdata, ramping_up, ov_detect} = '0;
        {vset_code, vtrack_code, vtgt} = {3{12'h3e8}};
        temp_dc = 16'sd250;
        seed = 32'h000114cd;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            apb(8'(k * 4), 1'b0, 32'h0);
            chk32(rd, 32'h0);
        end
        apb(8'h20, 1'b1, 32'hffffffff);
        chkb(perr, 1'b1);
        apb(8'h00, 1'b0, 32'h0);
        chk32(rd, 32'h0);
        apb(8'h04, 1'b1, 32'h00000142);
        apb(8'h00, 1'b1, 32'h00004001);
        cyc(80);
        chkb(good, 1'b0);
        cyc(40);
        chkb(good, 1'b1);
        chk32(32'(fall_slew_sel), 32'h5);
        apb(8'h00, 1'b1, 32'h00000001);
        eg = 1'b1;
        for (int k = 0; k < 30; k++)
        begin
            seed = xs(seed);
            vtgt <= 12'((32'd70 + seed % 51) * 10);
            cyc(8);
            eg = inwin(vtgt, vset_code, eg);
            chkb(good, eg);
        end
        vtgt <= 12'h3e8;
        apb(8'h0c, 1'b1, 32'h00000001);
        apb(8'h00, 1'b1, 32'h00000005);
        vtgt <= 12'd840;
        cyc(585);
        apb(8'h08, 1'b0, 32'h0);
        chk32(rd & 32'h1, 32'h0);
        poll(8'h08, 32'h1, 32'h1);
        cyc(0);
        chkb(irq, 1'b1);
        chkb(ramp_down_req, 1'b0);
        cyc(25);
        chkb(ramp_down_req, 1'b1);
        @(posedge pclk);
        vtgt <= 12'h3e8;
        apb(8'h0c, 1'b1, 32'h0);
        cyc(0);
        chkb(irq, 1'b0);
        apb(8'h0c, 1'b1, 32'h1);
        apb(8'h10, 1'b1, 32'h1);
        cyc(1);
        chkb(irq, 1'b0);
        poll(8'h14, 32'h1c, 32'h04);
        apb(8'h00, 1'b1, 32'h00000021);
        for (int k = 0; k < 4; k++)
        begin
            temp_dc <= tt[k];
            cyc(3);
            chkb(warn, tw[k]);
            @(posedge pclk);
        end
        temp_dc <= 16'sd1200;
        poll(8'h08, 32'h2, 32'h2);
        cyc(2);
        for (int k = 0; k < 8; k++)
        begin
            cyc(1);
            chk32({hs_drive, ls_drive}, 32'h0);
        end
        @(posedge pclk);
        temp_dc <= 16'sd1150;
        cyc(150);
        apb(8'h14, 1'b0, 32'h0);
        chk32(rd & 32'h1c, 32'h10);
        temp_dc <= 16'sd1080;
        poll(8'h14, 32'h1c, 32'h04);
        apb(8'h00, 1'b1, 32'h00000801);
        ramping_up <= 1'b1;
        vtrack_code <= 12'd1101;
        poll(8'h08, 32'h4, 32'h4);
        ramping_up <= 1'b0;
        vtrack_code <= 12'h3e8;
        apb(8'h00, 1'b1, 32'h0);
        poll(8'h14, 32'h1c, 32'h0);
        apb(8'h00, 1'b1, 32'h00000401);
        poll(8'h14, 32'h1c, 32'h04);
        ov_detect <= 1'b1;
        cyc(3);
        @(posedge pclk);
        ov_detect <= 1'b0;
        cyc(100);
        chk32({hs_drive, ls_drive}, 32'h1);
        apb(8'h00, 1'b1, 32'h0);
        poll(8'h14, 32'h1c, 32'h0);
        apb(8'h00, 1'b1, 32'h00030001);
        poll(8'h14, 32'h1c, 32'h04);
        apb(8'h00, 1'b1, 32'h00030000);
        cyc(50);
        chkb(good, 1'b1);
        cyc(70);
        chkb(good, 1'b0);
        complete_run();
    end
endmodule : converter_fault_and_power_good_tb_top

// ==== sim/power_stage_model.sv ====
// Power stage and measurement path seen by the supervisor.
// Assumes pclk domain; pwm requests never overlap, with dead cycles.
`timescale 1ns/1ps
module power_stage_model #(
    parameter int RAMP_CYC = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ramp_down_req,
    input  wire logic [11:0] vout_target,
    output logic             pwm_hs,
    output logic             pwm_ls,
    output logic             ramp_done,
    output logic [11:0]      vout_code
);
    logic [3:0] ph_q;
    logic [7:0] rc_q;
    // Phase counter, ramp timer, one-cycle measurement delay
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_q      <= 4'h0;
            rc_q      <= 8'h00;
            vout_code <= 12'h000;
        end
        else
        begin
            ph_q      <= ph_q + 4'h1;
            rc_q      <= ramp_down_req ? rc_q + 8'h01 : 8'h00;
            vout_code <= vout_target;
        end
    end
    // Requests and ramp completion
    assign pwm_hs    = ph_q[3:2] == 2'h1;
    assign pwm_ls    = ph_q[3:2] == 2'h3;
    assign ramp_done = rc_q >= 8'(RAMP_CYC);
endmodule : power_stage_model
